// *** hdl/odpr_block.v ***
// Purpose: parameter bytes and diagnostic record of an eight-channel digital output module
// Assumes: backplane requests arrive as one-cycle strobes on i_clk; fault inputs are asynchronous
// Notes:   one byte per read or write; answers are registered one cycle after the strobe
//
// Summary of operation
// - interrupt enable byte 00h disables, 40h enables diagnostic interrupts.
// - wire-break enable byte, bit n turns detection on for channel n.
// - short-circuit enable byte, bit n turns detection on for channel n.
// - record set 01h returns whole record, set 00h only first four bytes.
// - index 2F01h serves whole record, index 2F00h only first four bytes.
// - first diagnostic byte flags failure, internal, external, channel, aux supply, parameter errors.
// - record holds constant diagnostic bits per channel, value 08h.
// - record holds constant channel count, value 08h.
// - record holds one error byte per channel, each reset to 00h.
// - parameter bytes reached at index 3100h plus slot, subindexes 01h to 03h.
// - diagnostic record bytes reached at index 5005h, one subindex per byte.
// - channel error byte: bit0 parameter, bit2 short plus, bit3 short ground, bit4 wire-break.
// - channel error summary bit n set whenever channel n has an error.
// - 32-bit microsecond counter from zero, wraps, captured when a flag of record byte 0 or 7 rises.
`include "odpr_map.vh"
module odpr_block (
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_run_mode,
   input  wire [7:0]  i_slot,
   input  wire        i_req,
   input  wire        i_write,
   input  wire [1:0]  i_path,
   input  wire [7:0]  i_record_set_number,
   input  wire [15:0] i_object_index,
   input  wire [7:0]  i_object_subindex,
   input  wire [4:0]  i_byte_offset,
   input  wire [7:0]  i_wdata,
   input  wire [7:0]  i_wire_break,
   input  wire [7:0]  i_short_plus,
   input  wire [7:0]  i_short_ground,
   input  wire        i_aux_missing,
   input  wire        i_internal_fault,
   input  wire        i_comm_fault,
   output reg         o_ack,
   output reg         o_nak,
   output reg  [7:0]  o_rdata,
   output reg         o_diag_irq,
   output wire [7:0]  o_wire_break_detect_enable,
   output wire [7:0]  o_short_detect_enable
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   reg  [7:0]  diag_interrupt_enable;
   reg  [7:0]  wire_break_detect_enable;
   reg  [7:0]  short_detect_enable;
   reg  [7:0]  chan_err [0:7];
   reg         param_error;
   reg  [31:0] us_counter;
   reg  [6:0]  us_div;
   reg  [31:0] diag_timestamp_us;
   reg  [7:0]  prev_a;
   reg  [7:0]  prev_map;
   reg  [26:0] sync1;
   reg  [26:0] sync2;
   reg  [26:0] sync3;
   reg  [26:0] flt;
   reg         rd_ok;
   reg         wr_ok;
   reg  [4:0]  rd_idx;
   reg  [1:0]  wr_sel;
   reg  [7:0]  rd_byte;
   reg         par_rd;
   reg  [7:0]  par_byte;
   reg  [7:0]  next_chan [0:7];
   wire [7:0]  channel_error_map;
   wire [7:0]  module_error_summary;
   wire [7:0]  module_error_extra;
   wire [15:0] param_index;
   wire        flag_rise;
   integer     k;
   integer     j;

   assign o_wire_break_detect_enable = wire_break_detect_enable;
   assign o_short_detect_enable      = short_detect_enable;
   assign param_index = `ODPR_IX_PARAM + {8'h00, i_slot};

   // ----------------------------------------
   // fault input synchronisers
   // ----------------------------------------
   // a level is accepted only once the second and third stages agree
   // vector: wire-break, short plus, short ground per channel, then aux, internal, comm
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sync1 <= 27'h0;
         sync2 <= 27'h0;
         sync3 <= 27'h0;
         flt   <= 27'h0;
      end else begin
         sync1 <= {i_comm_fault, i_internal_fault, i_aux_missing, i_short_ground, i_short_plus, i_wire_break};
         sync2 <= sync1;
         sync3 <= sync2;
         flt   <= (sync2 & sync3) | (flt & (sync2 | sync3));
      end
   end

   // ----------------------------------------
   // channel errors
   // ----------------------------------------
   // an interrupt enable byte written with a value other than 00h or 40h is flagged on every channel
   always @* begin
      for (j = 0; j < 8; j = j + 1) begin
         next_chan[j] = `ODPR_ZERO8;
         next_chan[j][`ODPR_CE_PARM]    = param_error;
         next_chan[j][`ODPR_CE_SHORT_P] = flt[`ODPR_F_SHORT_P + j] & short_detect_enable[j];
         next_chan[j][`ODPR_CE_SHORT_M] = flt[`ODPR_F_SHORT_M + j] & short_detect_enable[j];
         next_chan[j][`ODPR_CE_WIRE]    = flt[j] & wire_break_detect_enable[j];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_map
         assign channel_error_map[g] = |chan_err[g];
      end
   endgenerate

   assign module_error_summary = {param_error, 2'b00, flt[`ODPR_F_AUX], |channel_error_map,
                                  flt[`ODPR_F_AUX] | flt[`ODPR_F_INT], flt[`ODPR_F_INT], flt[`ODPR_F_INT]};
   assign module_error_extra   = {3'b000, flt[`ODPR_F_COMM], 4'h0};

   // a flag counts as new only on the cycle it rises; falling flags raise nothing
   function rising_any;
      input [7:0] now_a;
      input [7:0] was_a;
      input [7:0] now_m;
      input [7:0] was_m;
      begin
         rising_any = |((now_a & ~was_a) | (now_m & ~was_m));
      end
   endfunction
   assign flag_rise = rising_any(module_error_summary, prev_a, channel_error_map, prev_map);

   // ----------------------------------------
   // microsecond counter and event capture
   // ----------------------------------------
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         us_div            <= 7'h00;
         us_counter        <= 32'h0;
         diag_timestamp_us <= 32'h0;
         prev_a            <= 8'h00;
         prev_map          <= 8'h00;
         o_diag_irq        <= 1'b0;
         for (k = 0; k < 8; k = k + 1) begin
            chan_err[k] <= 8'h00;
         end
      end else begin
         if (us_div == `ODPR_US_TOP) begin
            us_div     <= 7'h00;
            us_counter <= us_counter + 32'h1;
         end else begin
            us_div <= us_div + 7'h01;
         end
         for (k = 0; k < 8; k = k + 1) begin
            chan_err[k] <= next_chan[k];
         end
         prev_a   <= module_error_summary;
         prev_map <= channel_error_map;
         // timestamp taken whenever a flag of record byte 0 or of the channel summary byte 7 rises
         if (flag_rise) begin
            diag_timestamp_us <= us_counter;
         end
         // flags of one event may rise on neighbouring cycles; they merge into one pulse
         o_diag_irq <= (diag_interrupt_enable == `ODPR_IRQ_ON) && flag_rise && !o_diag_irq;
      end
   end

   // ----------------------------------------
   // request decode
   // ----------------------------------------
   always @* begin
      par_rd = 1'b0;
      rd_ok  = 1'b0;
      wr_ok  = 1'b0;
      rd_idx = i_byte_offset;
      wr_sel = 2'h0;
      case (i_path)
         `ODPR_PATH_SET: begin
            if (i_record_set_number == `ODPR_SET_FULL) begin
               rd_ok = i_byte_offset < `ODPR_REC_LEN;
            end else if (i_record_set_number == `ODPR_SET_SHORT) begin
               rd_ok = i_byte_offset < `ODPR_SHORT_LEN;
               wr_ok = i_byte_offset < `ODPR_PARAM_BYTES;
               wr_sel = i_byte_offset[1:0];
            end
         end
         `ODPR_PATH_INDEX: begin
            if (i_object_index == `ODPR_IX_FULL) begin
               rd_ok = i_byte_offset < `ODPR_REC_LEN;
            end else if (i_object_index == `ODPR_IX_SHORT) begin
               rd_ok = i_byte_offset < `ODPR_SHORT_LEN;
            end else if (i_object_index >= `ODPR_IX_PARAM && i_object_index < `ODPR_IX_PARAM + `ODPR_PARAM_COUNT) begin
               // a parameter byte reads back as stored; the enables are read-write
               rd_ok  = 1'b1;
               par_rd = 1'b1;
               wr_ok  = 1'b1;
               wr_sel = i_object_index[1:0];
            end
         end
         `ODPR_PATH_SUB: begin
            if (i_object_index == `ODPR_IX_DIAG_SUB && i_object_subindex >= `ODPR_SUB_FIRST &&
                i_object_subindex <= `ODPR_SUB_LAST) begin
               rd_ok  = 1'b1;
               rd_idx = i_object_subindex[4:0] - `ODPR_SUB_BASE;
            end else if (i_object_index == param_index && i_object_subindex >= `ODPR_SUB_IRQ &&
                         i_object_subindex <= `ODPR_SUB_SHORT) begin
               rd_ok  = 1'b1;
               par_rd = 1'b1;
               wr_ok  = 1'b1;
               wr_sel = i_object_subindex[1:0] - 2'h1;
            end
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
      if (i_write) begin
         rd_ok = 1'b0;
      end else begin
         wr_ok = 1'b0;
      end
   end

   // record byte layout; bytes past channel seven hold the timestamp
   always @* begin
      case (rd_idx)
         5'h00:   rd_byte = module_error_summary;
         5'h01:   rd_byte = `ODPR_CLASS_INFO;
         5'h02:   rd_byte = `ODPR_ZERO8;
         5'h03:   rd_byte = module_error_extra;
         5'h04:   rd_byte = `ODPR_CHAN_KIND;
         5'h05:   rd_byte = `ODPR_BITS_PER_CH;
         5'h06:   rd_byte = `ODPR_NUM_CH;
         5'h07:   rd_byte = channel_error_map;
         5'h08:   rd_byte = chan_err[0];
         5'h09:   rd_byte = chan_err[1];
         5'h0a:   rd_byte = chan_err[2];
         5'h0b:   rd_byte = chan_err[3];
         5'h0c:   rd_byte = chan_err[4];
         5'h0d:   rd_byte = chan_err[5];
         5'h0e:   rd_byte = chan_err[6];
         5'h0f:   rd_byte = chan_err[7];
         5'h10:   rd_byte = diag_timestamp_us[7:0];
         5'h11:   rd_byte = diag_timestamp_us[15:8];
         5'h12:   rd_byte = diag_timestamp_us[23:16];
         5'h13:   rd_byte = diag_timestamp_us[31:24];
         default: rd_byte = `ODPR_ZERO8;
      endcase
   end

   // stored parameter byte picked by the same select that a write would use
   always @* begin
      case (wr_sel)
         2'h0:    par_byte = diag_interrupt_enable;
         2'h1:    par_byte = wire_break_detect_enable;
         default: par_byte = short_detect_enable;
      endcase
   end

   // ----------------------------------------
   // parameter writes and answers
   // ----------------------------------------
   // writes in run mode are refused; the controller is expected to stop first
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         diag_interrupt_enable    <= `ODPR_IRQ_OFF;
         wire_break_detect_enable <= 8'h00;
         short_detect_enable      <= 8'h00;
         param_error              <= 1'b0;
         o_ack                    <= 1'b0;
         o_nak                    <= 1'b0;
         o_rdata                  <= 8'h00;
      end else begin
         o_ack <= i_req & ((wr_ok & ~i_run_mode) | rd_ok);
         o_nak <= i_req & ~((wr_ok & ~i_run_mode) | rd_ok);
         if (i_req & rd_ok) begin
            o_rdata <= par_rd ? par_byte : rd_byte;
         end
         if (i_req & wr_ok & ~i_run_mode) begin
            case (wr_sel)
               2'h0: begin
                  diag_interrupt_enable <= i_wdata;
                  param_error <= (i_wdata != `ODPR_IRQ_OFF) && (i_wdata != `ODPR_IRQ_ON);
               end
               2'h1: wire_break_detect_enable <= i_wdata;
               2'h2: short_detect_enable <= i_wdata;
               default: param_error <= 1'b1;
            endcase
         end
      end
   end
endmodule

// *** pkg/odpr_map.vh ***
// Purpose: constants for the output diagnostic parameter and record block
// Assumes: byte-wide record access, one byte per request
// Notes:   definitions only
`ifndef ODPR_MAP_VH
`define ODPR_MAP_VH
// ----------------------------------------
// parameter values and record constants
// ----------------------------------------
`define ODPR_IRQ_OFF        8'h00
`define ODPR_IRQ_ON         8'h40
`define ODPR_CLASS_INFO     8'h1f
`define ODPR_CHAN_KIND      8'h72
`define ODPR_BITS_PER_CH    8'h08
`define ODPR_NUM_CH         8'h08
`define ODPR_ZERO8          8'h00
// ----------------------------------------
// access paths
// ----------------------------------------
`define ODPR_PATH_SET       2'h0
`define ODPR_PATH_INDEX     2'h1
`define ODPR_PATH_SUB       2'h2
`define ODPR_SET_SHORT      8'h00
`define ODPR_SET_FULL       8'h01
`define ODPR_IX_SHORT       16'h2f00
`define ODPR_IX_FULL        16'h2f01
`define ODPR_IX_PARAM       16'h3100
`define ODPR_IX_DIAG_SUB    16'h5005
`define ODPR_SUB_IRQ        8'h01
`define ODPR_SUB_WIRE       8'h02
`define ODPR_SUB_SHORT      8'h03
`define ODPR_SUB_FIRST      8'h02
`define ODPR_SUB_LAST       8'h15
`define ODPR_SHORT_LEN      5'h04
`define ODPR_REC_LEN        5'h14
`define ODPR_PARAM_BYTES    5'h03
`define ODPR_PARAM_COUNT    16'h0003
`define ODPR_SUB_BASE       5'h02
// ----------------------------------------
// field positions
// ----------------------------------------
`define ODPR_A_FAIL         0
`define ODPR_A_INT          1
`define ODPR_A_EXT          2
`define ODPR_A_CHAN         3
`define ODPR_A_AUX          4
`define ODPR_A_PARM         7
`define ODPR_CE_PARM        0
`define ODPR_CE_SHORT_P     2
`define ODPR_CE_SHORT_M     3
`define ODPR_CE_WIRE        4
`define ODPR_D_COMM         4
`define ODPR_F_SHORT_P      8
`define ODPR_F_SHORT_M      16
`define ODPR_F_AUX          24
`define ODPR_F_INT          25
`define ODPR_F_COMM         26
// ----------------------------------------
// timing
// ----------------------------------------
`define ODPR_CLK_MHZ        100
`define ODPR_US_CYCLES      (`ODPR_CLK_MHZ)
`define ODPR_US_TOP         7'h63
`endif

// *** verif/odpr_block_bench.sv ***
// Purpose: self-checking bench for the parameter and record block
// Assumes: inputs change at the falling edge
// Notes:   fault filter delay is covered by an eight-cycle settle
`include "odpr_map.vh"
module odpr_block_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk = 0, i_rst = 1, i_run_mode = 0, i_req, i_write, o_ack, o_nak, o_diag_irq;
   logic        i_aux_missing = 0, i_internal_fault = 0, i_comm_fault = 0;
   logic [1:0]  i_path;
   logic [4:0]  i_byte_offset;
   logic [15:0] i_object_index;
   logic [7:0]  i_slot = 0, i_record_set_number, i_object_subindex, i_wdata, o_rdata;
   logic [7:0]  i_wire_break = 0, i_short_plus = 0, i_short_ground = 0;
   logic [7:0]  o_wire_break_detect_enable, o_short_detect_enable;
   logic [9:0]  expq[$];
   logic [9:0]  e;
   logic [2:0]  c;
   int          mismatches = 0, total_checks = 0, irqs = 0, seed = 66566, n;
   odpr_block odpr_block_inst (.*);
   odpr_ctl odpr_ctl_inst (.i_clk(i_clk), .o_req(i_req), .o_write(i_write), .o_path(i_path),
      .o_set(i_record_set_number), .o_index(i_object_index), .o_sub(i_object_subindex),
      .o_off(i_byte_offset), .o_wdata(i_wdata));
   initial forever #5 i_clk = ~i_clk;
   initial begin
      #200us;
      mismatches++;
      give_verdict();
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [8:0] s, input logic [8:0] x);
      total_checks++;
      if (s !== x) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, s, x);
      end
   endtask
   // expected answer {read, refused, byte} is queued before the request goes out
   task automatic op(input logic w, input logic [1:0] p, input logic [15:0] a, input logic [7:0] s,
                     input logic [4:0] f, input logic [7:0] d, input logic [8:0] x);
      expq.push_back({~w, x});
      odpr_ctl_inst.xfer(w, p, a, s, f, d);
   endtask
   task automatic rd(input logic [4:0] f, input logic [7:0] x);
      op(1'b0, 2'h0, 16'h0001, 8'h00, f, 8'h00, {1'b0, x});
   endtask
   task automatic flt(input logic [7:0] w, input logic [7:0] p, input logic [7:0] g, input logic [7:0] d);
      {i_wire_break, i_short_plus, i_short_ground} = {w, p, g};
      repeat (8) @(negedge i_clk);
      rd(5'h07, 8'h01 << c);
      rd(5'h08 + c, d);
      rd(5'h00, {4'h0, |(w | p | g), 3'h0});
   endtask
   function automatic logic [7:0] rv(input int k);
      return k == 1 ? 8'h1f : k == 4 ? 8'h72 : (k == 5 || k == 6) ? 8'h08 : 8'h00;
   endfunction
   always @(posedge i_clk) begin
      if (o_diag_irq === 1'b1) irqs++;
      #1;
      if (o_ack === 1'b1 || o_nak === 1'b1) begin
         e = expq.pop_front();
         chk({o_nak, e[9] ? o_rdata : e[7:0]}, e[8:0]);
      end
   end
   initial begin
      i_slot = 8'($random(seed));
      c = 3'($random(seed));
      repeat (4) @(negedge i_clk);
      i_rst = 0;
      for (n = 0; n < 20; n++) begin
         rd(n[4:0], rv(n));
         op(1'b0, 2'h1, 16'h2f01, 8'h00, n[4:0], 8'h00, {1'b0, rv(n)});
         op(1'b0, 2'h2, 16'h5005, 8'(n + 2), 5'h00, 8'h00, {1'b0, rv(n)});
      end
      op(1'b0, 2'h0, 16'h0000, 8'h00, 5'h03, 8'h00, 9'h000);
      op(1'b0, 2'h0, 16'h0000, 8'h00, 5'h04, 8'h00, 9'h100);
      op(1'b0, 2'h1, 16'h2f00, 8'h00, 5'h04, 8'h00, 9'h100);
      op(1'b0, 2'h2, 16'h5005, 8'h16, 5'h00, 8'h00, 9'h100);
      $display("test record reads done");
      op(1'b1, 2'h2, 16'h3100 + i_slot, 8'h01, 5'h00, 8'h40, 9'h000);
      op(1'b1, 2'h0, 16'h0000, 8'h00, 5'h01, 8'h01 << c, 9'h000);
      op(1'b1, 2'h0, 16'h0000, 8'h00, 5'h02, 8'h01 << c, 9'h000);
      op(1'b0, 2'h2, 16'h3100 + i_slot, 8'h01, 5'h00, 8'h00, 9'h040);
      op(1'b0, 2'h2, 16'h3100 + i_slot, 8'h03, 5'h00, 8'h00, {1'b0, 8'h01 << c});
      // system running: the controller would never write here, the refusal is what is tested
      i_run_mode = 1;
      op(1'b1, 2'h1, 16'h3101, 8'h00, 5'h00, 8'hff, 9'h100);
      i_run_mode = 0;
      chk({1'b0, o_wire_break_detect_enable}, {1'b0, 8'h01 << c});
      $display("test parameter access done");
      flt(8'hff, 8'h00, 8'h00, 8'h10);
      chk(9'(irqs), 9'h001);
      flt(8'h00, 8'hff, 8'h00, 8'h04);
      flt(8'h00, 8'h00, 8'hff, 8'h08);
      op(1'b1, 2'h1, 16'h3100, 8'h00, 5'h00, 8'h00, 9'h000);
      n = irqs;
      {i_short_ground, i_aux_missing, i_comm_fault, i_internal_fault} = {8'h00, 3'b111};
      repeat (8) @(negedge i_clk);
      rd(5'h00, 8'h17);
      rd(5'h03, 8'h10);
      chk(9'(irqs - n), 9'h000);
      {i_aux_missing, i_comm_fault, i_internal_fault} = 3'b000;
      repeat (8) @(negedge i_clk);
      op(1'b1, 2'h0, 16'h0000, 8'h00, 5'h00, 8'h13, 9'h000);
      rd(5'h00, 8'h88);
      rd(5'h08 + c, 8'h01);
      repeat (3) @(negedge i_clk);
      chk(9'(expq.size()), 9'h000);
      $display("test diagnostics done");
      give_verdict();
   end
endmodule

// *** verif/odpr_checker.sv ***
// Purpose: port-level checks of the parameter and record block
// Assumes: answers come exactly one cycle after the strobe
// Notes:   bound to the block, watches its ports only
module odpr_checker (
   input wire       i_clk,
   input wire       i_rst,
   input wire       i_run_mode,
   input wire       i_req,
   input wire       i_write,
   input wire [1:0] i_path,
   input wire [7:0] i_record_set_number,
   input wire [4:0] i_byte_offset,
   input wire [7:0] i_wdata,
   input wire       o_ack,
   input wire       o_nak,
   input wire [7:0] o_rdata,
   input wire       o_diag_irq,
   input wire [7:0] o_wire_break_detect_enable,
   input wire [7:0] o_short_detect_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // rule checks
   // ----------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire rd1 = i_req && !i_write && i_path == 2'h0 && i_record_set_number == 8'h01;
   wire wr0 = i_req && i_write && !i_run_mode && i_path == 2'h0 && i_record_set_number == 8'h00;
   run_write_nak_a: assert property (i_req && i_write && i_run_mode |=> o_nak && !o_ack)
      else $error("write in run mode accepted");
   short_set_a: assert property (i_req && !i_write && i_path == 2'h0 && i_record_set_number == 8'h00
      && i_byte_offset > 5'h03 |=> o_nak) else $error("short set served past byte 3");
   idle_quiet_a: assert property (!i_req |=> !o_ack && !o_nak) else $error("answer without request");
   bits_const_a: assert property (rd1 && i_byte_offset == 5'h05 |=> o_ack && o_rdata == 8'h08)
      else $error("bits per channel wrong");
   chan_count_a: assert property (rd1 && i_byte_offset == 5'h06 |=> o_ack && o_rdata == 8'h08)
      else $error("channel count wrong");
   wire_en_a: assert property (wr0 && i_byte_offset == 5'h01 |=> o_wire_break_detect_enable == $past(i_wdata))
      else $error("wire enable not written");
   short_en_a: assert property (wr0 && i_byte_offset == 5'h02 |=> o_short_detect_enable == $past(i_wdata))
      else $error("short enable not written");
   irq_pulse_a: assert property (o_diag_irq |=> !o_diag_irq) else $error("interrupt longer than a cycle");
endmodule
bind odpr_block odpr_checker odpr_checker_inst (.*);

// *** verif/odpr_ctl.sv ***
// Purpose: controller model issuing parameter and record requests
// Assumes: one request per call, launched at the falling edge
// Notes:   index, subindex and write data are inverted on release so a stale value cannot pass
module odpr_ctl (
   input  wire         i_clk,
   output logic        o_req,
   output logic        o_write,
   output logic [1:0]  o_path,
   output logic [7:0]  o_set,
   output logic [15:0] o_index,
   output logic [7:0]  o_sub,
   output logic [4:0]  o_off,
   output logic [7:0]  o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {o_req, o_write, o_path, o_set, o_index, o_sub, o_off, o_wdata} = '0;
   task automatic xfer(input logic w, input logic [1:0] p, input logic [15:0] a, input logic [7:0] s,
                       input logic [4:0] f, input logic [7:0] d);
      @(negedge i_clk);
      {o_write, o_path, o_index, o_set, o_sub, o_off, o_wdata} = {w, p, a, a[7:0], s, f, d};
      o_req = 1'b1;
      @(negedge i_clk);
      o_req = 1'b0;
      {o_index, o_sub, o_wdata} = ~{o_index, o_sub, o_wdata};
   endtask
endmodule
